// [vst_defines.vh]
`ifndef VST_DEFINES_VH
`define VST_DEFINES_VH

// ****************************************
// clocking
// ****************************************
`define VST_REF_CLK_MHZ   100
`define VST_PIX_CLK_MHZ   25

// ****************************************
// horizontal timing, pixel clocks
// ****************************************
`define VST_H_SYNC        96
`define VST_H_BACK        48
`define VST_H_VISIBLE     640
`define VST_H_FRONT       16

// ****************************************
// vertical timing, lines
// ****************************************
`define VST_V_SYNC        2
`define VST_V_BACK        33
`define VST_V_VISIBLE     480
`define VST_V_FRONT       10

// ****************************************
// pixel word layout
// ****************************************
`define VST_COLOUR_W      4
`define VST_RED_LSB       8
`define VST_GREEN_LSB     4
`define VST_BLUE_LSB      0
`define VST_FIFO_DEPTH    32

`endif

// [vst_monitor.sv]
`timescale 1ns/1ns
// ****
// monitor: locates each pixel from the syncs
// ****
module vst_monitor (
  input  wire        i_clk,
  input  wire        i_hs,
  input  wire        i_vs,
  output wire        o_seen,
  output wire [15:0] o_pix,
  output reg  [15:0] o_line
);
  reg        hs_q, vs_q;
  reg [15:0] hc_r;
  wire [15:0] pos = (hs_q && !i_hs) ? 16'h0 : hc_r;
  // sample mid pixel, away from the edges where colour changes
  assign o_seen = (pos[1:0] == 2'h2);
  assign o_pix = pos >> 2;
  always @(posedge i_clk) begin
    hs_q <= i_hs;
    vs_q <= i_vs;
    hc_r <= pos + 16'h1;
    if (hs_q && !i_hs) o_line <= (vs_q && !i_vs) ? 16'h0 : o_line + 16'h1;
  end
endmodule

// [vst_sync_gen.v]
// Operation
// R1: horizontal sync is driven low for 96 pixel clocks at the start of each row and high otherwise.
// R2: after the horizontal sync pulse the colour outputs are held at zero for 48 pixel clocks.
// R3: after the back porch one pixel colour is shown per pixel clock for 640 pixel clocks in order.
// R4: after the visible interval the colour outputs are zero for 16 pixel clocks before the next sync.
// R5: vertical timing uses 2 sync, 33 back porch, 480 visible and 10 front porch lines per frame.
// R6: red, green and blue each leave the block as a 4-bit value for an external resistor DAC.
// R7: both sync outputs come straight from the block's flip-flops as digital levels.
// R8: all timing counts advance at a 25 MHz pixel rate to form the 640x480 mode.
// R9: a pixel counter wraps after the full row and a line counter advances per row and wraps per frame.
`timescale 1ns/1ns
`include "vst_defines.vh"

// ****************************************
// pixel fifo
// ****************************************
module vst_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = `VST_FIFO_DEPTH,
  parameter AW    = 5
) (
  // clock and reset
  input  wire             i_ref_clk,
  input  wire             i_srst,
  // fill side
  input  wire [WIDTH-1:0] i_wr_data,
  input  wire             i_wr_valid,
  output wire             o_wr_ready,
  // drain side
  output wire [WIDTH-1:0] o_rd_data,
  output wire             o_rd_valid,
  input  wire             i_rd_ready
);
  localparam [31:0] DEPTH_W = DEPTH;
  localparam [31:0] LAST_W  = DEPTH - 1;

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_r;
  reg  [AW-1:0]    wr_ptr_nxt;
  reg  [AW-1:0]    rd_ptr_r;
  reg  [AW-1:0]    rd_ptr_nxt;
  reg  [AW:0]      count_r;
  reg  [AW:0]      count_nxt;
  wire             push;
  wire             pop;

  assign o_wr_ready = (count_r != DEPTH_W[AW:0]);
  assign o_rd_valid = (count_r != {(AW+1){1'b0}});
  assign o_rd_data  = mem[rd_ptr_r];
  assign push       = i_wr_valid & o_wr_ready;
  assign pop        = i_rd_ready & o_rd_valid;

  // ****************************************
  // storage
  // ****************************************
  // no reset on the array, so it can sit in block memory
  always @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= i_wr_data;
    end
  end

  // ****************************************
  // pointers and fill count
  // ****************************************
  // pointers wrap explicitly so depth need not be a power of two
  always @* begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == LAST_W[AW-1:0]) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == LAST_W[AW-1:0]) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
    end
    if (push & ~pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop & ~push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end
endmodule

// ****************************************
// sync and colour generator
// ****************************************
module vst_sync_gen #(
  parameter CW      = `VST_COLOUR_W,
  parameter H_SYNC  = `VST_H_SYNC,
  parameter H_BACK  = `VST_H_BACK,
  parameter H_VIS   = `VST_H_VISIBLE,
  parameter H_FRONT = `VST_H_FRONT,
  parameter V_SYNC  = `VST_V_SYNC,
  parameter V_BACK  = `VST_V_BACK,
  parameter V_VIS   = `VST_V_VISIBLE,
  parameter V_FRONT = `VST_V_FRONT,
  parameter DEPTH   = `VST_FIFO_DEPTH
) (
  // clock and reset
  input  wire          i_ref_clk,
  input  wire          i_srst,
  // pixel stream in
  input  wire [3*CW-1:0] i_pix_data,
  input  wire          i_pix_valid,
  output wire          o_pix_ready,
  // monitor side
  output wire          o_horizontal_sync_out,
  output wire          o_vertical_sync_out,
  output wire [CW-1:0] o_red,
  output wire [CW-1:0] o_green,
  output wire [CW-1:0] o_blue,
  // status
  output wire          o_frame_start,
  output wire          o_underrun
);
  localparam DIV     = `VST_REF_CLK_MHZ / `VST_PIX_CLK_MHZ;
  localparam H_TOTAL = H_SYNC + H_BACK + H_VIS + H_FRONT;
  localparam V_TOTAL = V_SYNC + V_BACK + V_VIS + V_FRONT;
  localparam H_VBEG  = H_SYNC + H_BACK;
  localparam V_VBEG  = V_SYNC + V_BACK;
  localparam AW      = $clog2(DEPTH);

  // true when c lies in [lo, lo+len)
  function in_range;
    input [10:0] c;
    input [10:0] lo;
    input [10:0] len;
    begin
      in_range = (c >= lo) && (c < lo + len);
    end
  endfunction

  reg  [2:0]       div_r;
  reg  [2:0]       div_nxt;
  reg  [10:0]      h_cnt_r;
  reg  [10:0]      h_cnt_nxt;
  reg  [10:0]      v_cnt_r;
  reg  [10:0]      v_cnt_nxt;
  reg              hs_r;
  reg              hs_nxt;
  reg              vs_r;
  reg              vs_nxt;
  reg  [3*CW-1:0]  rgb_r;
  reg  [3*CW-1:0]  rgb_nxt;
  reg              frame_r;
  reg              frame_nxt;
  reg              under_r;
  reg              under_nxt;
  wire             pix_tick;
  wire             h_last;
  wire             v_last;
  wire             visible;
  wire [3*CW-1:0]  fifo_data;
  wire             fifo_valid;
  wire             fifo_pop;

  // ****************************************
  // pixel clock
  // ****************************************
  // 100 MHz reference divided down to the pixel rate [R8]
  assign pix_tick = (div_r == DIV[2:0] - 3'h1);

  always @* begin
    div_nxt = pix_tick ? 3'h0 : div_r + 3'h1;
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ****************************************
  // row and frame counters
  // ****************************************
  assign h_last = (h_cnt_r == H_TOTAL[10:0] - 11'h1);
  assign v_last = (v_cnt_r == V_TOTAL[10:0] - 11'h1);

  // the line counter only moves on the last pixel of a row [R9]
  always @* begin
    h_cnt_nxt = h_cnt_r;
    v_cnt_nxt = v_cnt_r;
    if (pix_tick) begin
      h_cnt_nxt = h_last ? 11'h000 : h_cnt_r + 11'h001;                 // [R9]
      if (h_last) begin
        v_cnt_nxt = v_last ? 11'h000 : v_cnt_r + 11'h001;               // [R5]
      end
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      h_cnt_r <= 11'h000;
      v_cnt_r <= 11'h000;
    end else begin
      h_cnt_r <= h_cnt_nxt;
      v_cnt_r <= v_cnt_nxt;
    end
  end

  // ****************************************
  // colour window
  // ****************************************
  // porches fall outside the horizontal window, so colour is zero there [R2] [R4]
  assign visible = in_range(h_cnt_r, H_VBEG[10:0], H_VIS[10:0]) &&
                   in_range(v_cnt_r, V_VBEG[10:0], V_VIS[10:0]);

  // one word leaves the fifo per visible pixel clock [R3]
  assign fifo_pop = pix_tick & visible;

  // ****************************************
  // pixel fifo
  // ****************************************
  // the fifo soaks up a bursty source against the fixed raster
  vst_fifo #(
    .WIDTH (3*CW),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .i_ref_clk  (i_ref_clk),
    .i_srst     (i_srst),
    .i_wr_data  (i_pix_data),
    .i_wr_valid (i_pix_valid),
    .o_wr_ready (o_pix_ready),
    .o_rd_data  (fifo_data),
    .o_rd_valid (fifo_valid),
    .i_rd_ready (fifo_pop)
  );

  // ****************************************
  // output registers
  // ****************************************
  // sync and colour outputs are flops updated on the pixel tick; frame start and underrun load every reference clock [R7]
  always @* begin
    hs_nxt    = hs_r;
    vs_nxt    = vs_r;
    rgb_nxt   = rgb_r;
    frame_nxt = pix_tick && (h_cnt_r == 11'h000) && (v_cnt_r == 11'h000);
    under_nxt = fifo_pop & ~fifo_valid;
    if (pix_tick) begin
      hs_nxt = ~in_range(h_cnt_r, 11'h000, H_SYNC[10:0]);                // [R1]
      vs_nxt = ~in_range(v_cnt_r, 11'h000, V_SYNC[10:0]);                // [R5]
      // an empty fifo shows black rather than stalling the raster
      if (visible && fifo_valid) begin
        rgb_nxt = fifo_data;                                              // [R3]
      end else begin
        rgb_nxt = {(3*CW){1'b0}};                                         // [R2] [R4]
      end
    end
  end

  // syncs idle high and colour idles black while reset is held
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      hs_r    <= 1'b1;
      vs_r    <= 1'b1;
      rgb_r   <= {(3*CW){1'b0}};
      frame_r <= 1'b0;
      under_r <= 1'b0;
    end else begin
      hs_r    <= hs_nxt;
      vs_r    <= vs_nxt;
      rgb_r   <= rgb_nxt;
      frame_r <= frame_nxt;
      under_r <= under_nxt;
    end
  end

  // ****************************************
  // monitor side
  // ****************************************
  assign o_horizontal_sync_out = hs_r;
  assign o_vertical_sync_out   = vs_r;
  assign o_frame_start         = frame_r;
  assign o_underrun            = under_r;

  // ****************************************
  // dac channels
  // ****************************************
  // split the packed word into the three dac channels [R6]
  genvar g;
  generate
    for (g = 0; g < CW; g = g + 1) begin : g_chan
      assign o_red[g]   = rgb_r[`VST_RED_LSB + g];
      assign o_green[g] = rgb_r[`VST_GREEN_LSB + g];
      assign o_blue[g]  = rgb_r[`VST_BLUE_LSB + g];
    end
  endgenerate
endmodule

// [vst_sync_gen_properties.sv]
`timescale 1ns/1ns
// ****
// raster checker
// ****
module vst_chk #(parameter CW = 4, H_SYNC = 96, H_BACK = 48, H_VIS = 640, H_FRONT = 16,
  V_SYNC = 2) (
  input wire            i_ref_clk, i_srst, i_pix_valid, o_pix_ready, o_frame_start, o_underrun,
  input wire [3*CW-1:0] i_pix_data,
  input wire            o_horizontal_sync_out, o_vertical_sync_out,
  input wire [CW-1:0]   o_red, o_green, o_blue
);
  localparam int ROW = 4 * (H_SYNC + H_BACK + H_VIS + H_FRONT);
  localparam int VSW = ROW * V_SYNC;
  wire hs = o_horizontal_sync_out;
  wire vs = o_vertical_sync_out;
  wire blk = ({o_red, o_green, o_blue} == 0);
  reg        hs_q, armed_r;
  reg [15:0] hc_r, hl_r, vl_r;
  // clocks since the row began, so porches are checked without the design's counters
  wire [15:0] pos = (hs_q && !hs) ? 16'h0 : hc_r;
  always @(posedge i_ref_clk) begin
    hs_q <= hs;
    hc_r <= pos + 16'h1;
    hl_r <= hs ? 16'h0 : hl_r + 16'h1;
    vl_r <= vs ? 16'h0 : vl_r + 16'h1;
    // no full row has been seen before the first row sync
    armed_r <= i_srst ? 1'b0 : (armed_r | (hs_q && !hs));
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  sequence s_row; $fell(hs); endsequence
  sequence s_frame; $fell(vs) ##0 $fell(hs); endsequence
  a_hs_width: assert property ($rose(hs) |-> hl_r == 4 * H_SYNC)
    else $error("row sync width wrong");
  a_row_period: assert property (s_row ##0 armed_r |-> hc_r == ROW)
    else $error("row period wrong");
  a_vs_width: assert property ($rose(vs) |-> vl_r == VSW)
    else $error("frame sync width wrong");
  a_vs_on_row: assert property ($fell(vs) |-> $fell(hs))
    else $error("frame sync off row start");
  a_back_porch: assert property (pos < 4 * (H_SYNC + H_BACK) |-> blk)
    else $error("colour in sync or back porch");
  a_front_porch: assert property (pos >= 4 * (H_SYNC + H_BACK + H_VIS) |-> blk)
    else $error("colour in front porch");
  a_frame_pulse: assert property (o_frame_start |-> s_frame)
    else $error("frame pulse off frame start");
  a_reset_state: assert property ($fell(i_srst) |-> o_pix_ready && hs && vs && blk)
    else $error("state after reset wrong");
endmodule

bind vst_sync_gen vst_chk #(.CW(CW), .H_SYNC(H_SYNC), .H_BACK(H_BACK), .H_VIS(H_VIS),
  .H_FRONT(H_FRONT), .V_SYNC(V_SYNC)) u_vst_chk (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
  .i_pix_valid(i_pix_valid), .o_pix_ready(o_pix_ready), .o_frame_start(o_frame_start),
  .o_underrun(o_underrun), .i_pix_data(i_pix_data),
  .o_horizontal_sync_out(o_horizontal_sync_out), .o_vertical_sync_out(o_vertical_sync_out),
  .o_red(o_red), .o_green(o_green), .o_blue(o_blue));

// [vst_sync_gen_tb.sv]
`timescale 1ns/1ns
// ****
// bench
// ****
module vst_sync_gen_tb;
  localparam HS = 4, HB = 3, HV = 8, VS = 2, VB = 2, VV = 3;
  reg         clk = 1'b0, srst = 1'b1, valid = 1'b0;
  reg  [11:0] data = 12'h0;
  wire        ready, hs, vs, fs, ur, seen;
  wire [3:0]  r, g, b;
  wire [15:0] pix, line;
  integer     err_total = 0, comparisons = 0, i, n_fs = 0;
  logic [11:0] q[$];
  always #5 clk = ~clk;
  always @(posedge clk) if (!srst && fs) n_fs <= n_fs + 1;
  vst_sync_gen #(.H_SYNC(HS), .H_BACK(HB), .H_VIS(HV), .H_FRONT(2), .V_SYNC(VS), .V_BACK(VB),
    .V_VIS(VV), .V_FRONT(2)) u_vst_sync_gen (.i_ref_clk(clk), .i_srst(srst),
    .i_pix_data(data), .i_pix_valid(valid), .o_pix_ready(ready),
    .o_horizontal_sync_out(hs), .o_vertical_sync_out(vs), .o_red(r), .o_green(g),
    .o_blue(b), .o_frame_start(fs), .o_underrun(ur));
  vst_monitor u_vst_monitor (.i_clk(clk), .i_hs(hs), .i_vs(vs), .o_seen(seen), .o_pix(pix),
    .o_line(line));
  task chk(input [11:0] seen_v, input [11:0] exp_v);
    comparisons = comparisons + 1;
    if (seen_v !== exp_v) begin
      err_total = err_total + 1;
      $display("MISMATCH %0t seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task end_of_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) if (!srst && seen) begin
    if (line >= VS + VB && line < VS + VB + VV && pix >= HS + HB && pix < HS + HB + HV)
      chk({r, g, b}, q.pop_front());
    else
      chk({r, g, b}, 12'h0);
    chk({11'h0, ur}, 12'h0);
  end
  initial begin
    void'($urandom(68));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    valid <= 1'b1;
    // 41 back-to-back offers before any pixel is shown: the fifo must refuse after 32
    for (i = 0; i < 1400; i = i + 1) begin
      @(posedge clk);
      if (valid && ready) q.push_back(data);
      if (i == 40) chk({11'h0, ready}, 12'h0);
      if (i == 40) chk(12'(q.size()), 12'h20);
      data <= 12'($urandom);
      valid <= (i < 40) ? 1'b1 : 1'($urandom);
    end
    // a frame is 612 clocks here, so three frame starts fall inside the run
    chk(12'(n_fs), 12'h3);
    end_of_test;
  end
endmodule
